// File: src/pomc_pkg.sv
// constants and types shared by the operating-mode control block
// assumes a single core clock domain and an active-high async reset
package pomc_pkg;

  // operating modes: three basic ones plus the two extended sub-modes
  typedef enum logic [2:0] {
    MODE_REAL,
    MODE_PROT,
    MODE_SMM,
    MODE_COMPAT,
    MODE_LONG64
  } pomc_mode_t;

  localparam int         MODE_COUNT = 5;
  localparam pomc_mode_t MODE_RST   = MODE_REAL;

  // size codes for operands, addresses and register accesses
  localparam logic [1:0] SZ_8  = 2'h0;
  localparam logic [1:0] SZ_16 = 2'h1;
  localparam logic [1:0] SZ_32 = 2'h2;
  localparam logic [1:0] SZ_64 = 2'h3;

  // byte lanes touched by a register access of each size
  localparam logic [7:0] LANES_8  = 8'h01;
  localparam logic [7:0] LANES_16 = 8'h03;
  localparam logic [7:0] LANES_32 = 8'h0f;
  localparam logic [7:0] LANES_64 = 8'hff;

  // register file shape per mode
  localparam logic [4:0] GPR_CNT_LEGACY = 5'h08;
  localparam logic [4:0] GPR_CNT_EXT    = 5'h10;
  localparam logic [6:0] GPR_W_LEGACY   = 7'h20;
  localparam logic [6:0] GPR_W_EXT      = 7'h40;
  localparam logic [6:0] LIN_W_LEGACY   = 7'h20;
  localparam logic [6:0] LIN_W_EXT      = 7'h40;

  // privilege levels: one bit per ring
  localparam logic [3:0] PRIV_ALL  = 4'hf;
  localparam logic [3:0] PRIV_NONE = 4'h1;

  // feature gate bit positions
  localparam int FEAT_PROT   = 0;
  localparam int FEAT_LONG   = 1;
  localparam int FEAT_RESUME = 2;
  localparam int FEAT_VM     = 3;
  localparam int FEAT_W      = 4;

  // pin synchroniser, idle high
  localparam int         SYNC_STAGES = 3;
  localparam logic [2:0] SYNC_RST    = 3'h7;

  // address space select
  localparam logic ASPACE_NORMAL = 1'b0;
  localparam logic ASPACE_MGMT   = 1'b1;

endpackage

// File: src/pomc_size_if.sv
// size decode bundle between mode control and the size decoder
// assumes the controller drives requests and the decoder answers
`timescale 1ns/1ps
interface pomc_size_if;
  import pomc_pkg::*;
  pomc_mode_t mode;
  logic       cs_d;
  logic       rex_w;
  logic       op_ovr;
  logic       ad_ovr;
  logic [1:0] acc_size;
  logic [3:0] reg_idx;
  logic [1:0] def_op;
  logic [1:0] def_ad;
  logic [1:0] eff_op;
  logic [1:0] eff_ad;
  logic [7:0] lane_mask;
  logic       reg_fault;

  modport dec (input mode, cs_d, rex_w, op_ovr, ad_ovr, acc_size, reg_idx,
               output def_op, def_ad, eff_op, eff_ad, lane_mask, reg_fault);
  modport ctl (output mode, cs_d, rex_w, op_ovr, ad_ovr, acc_size, reg_idx,
               input def_op, def_ad, eff_op, eff_ad, lane_mask, reg_fault);
endinterface

// File: src/pomc_size_dec.sv
// combinational operand, address and register-lane size decoder
// assumes inputs are stable within the cycle; results registered by caller
`timescale 1ns/1ps
module pomc_size_dec
  import pomc_pkg::*;
(
  pomc_size_if.dec sz
);

  // legacy size toggle by a size override prefix
  function automatic logic [1:0] toggle_sz(input logic [1:0] d,
                                           input logic       ovr);
    toggle_sz = ovr ? ((d == SZ_16) ? SZ_32 : SZ_16) : d;
  endfunction

  // byte lanes of a register access
  function automatic logic [7:0] lanes(input logic [1:0] s);
    case (s)
      SZ_8:    lanes = LANES_8;
      SZ_16:   lanes = LANES_16;
      SZ_32:   lanes = LANES_32;
      default: lanes = LANES_64;
    endcase
  endfunction

  // default and effective sizes per mode
  always_comb begin
    sz.def_op = SZ_16;
    sz.def_ad = SZ_16;
    sz.eff_op = toggle_sz(SZ_16, sz.op_ovr);
    sz.eff_ad = toggle_sz(SZ_16, sz.ad_ovr);
    case (sz.mode)
      MODE_PROT, MODE_COMPAT: begin
        sz.def_op = sz.cs_d ? SZ_32 : SZ_16;
        sz.def_ad = sz.def_op;
        sz.eff_op = toggle_sz(sz.def_op, sz.op_ovr);
        sz.eff_ad = toggle_sz(sz.def_ad, sz.ad_ovr);
      end
      MODE_LONG64: begin
        sz.def_op = SZ_32;
        sz.def_ad = SZ_64;
        sz.eff_op = sz.rex_w ? SZ_64 : (sz.op_ovr ? SZ_16 : SZ_32);
        sz.eff_ad = sz.ad_ovr ? SZ_32 : SZ_64;
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    sz.lane_mask = lanes(sz.acc_size);
    sz.reg_fault = (sz.mode != MODE_LONG64) &&
                   (sz.reg_idx[3] || (sz.acc_size == SZ_64));
  end

endmodule

// File: src/pomc_mode_ctrl.sv
// operating-mode control: mode state, management entry/return,
// per-mode environment and per-instruction size decode
// assumes same-clock control inputs; only the management pin is async
//
// Functional notes
// - active mode gates available features
// - reset starts in real-address mode
// - virtual attribute is per-task protected attribute
// - enter management mode on pin or message
// - entry saves context, switches address space
// - return restores exact prior state
// - extended mode has compat and 64-bit sub-modes
// - compat chosen per code segment
// - compat limits linear space to 4 GByte
// - compat uses 16/32-bit sizes only
// - compat: no virtual attribute, no task switch
// - compat supports all privilege levels
// - compat with extensions reaches above 4 GByte
// - 64-bit: 16 general and vector registers
// - 64-bit: general registers 64 bits wide
// - 64-bit linear space, per code segment
// - 64-bit: address 64, operand 32 default
// - prefixes override operand size per instruction
// - 64-bit decodes register extension prefix
// - 32-bit registers accessible as 8/16
`timescale 1ns/1ps
module pomc_mode_ctrl
  import pomc_pkg::*;
#(
  parameter int CTX_W = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             mgmt_irq_pin_n,
  input  wire logic             pic_mgmt_msg,
  input  wire logic             resume_req,
  input  wire logic             prot_enable_req,
  input  wire logic             prot_disable_req,
  input  wire logic             ext_mode_enable,
  input  wire logic             cs_load,
  input  wire logic             cs_long,
  input  wire logic             cs_default32,
  input  wire logic             task_load,
  input  wire logic             task_vm_attr,
  input  wire logic             task_switch_req,
  input  wire logic             pae_enable,
  input  wire logic [CTX_W-1:0] ctx_in,
  input  wire logic             rex_present,
  input  wire logic             rex_w,
  input  wire logic             rex_reg_ext,
  input  wire logic             op_size_prefix,
  input  wire logic             addr_size_prefix,
  input  wire logic [2:0]       reg_idx_in,
  input  wire logic [1:0]       reg_acc_size,
  output pomc_mode_t            cur_mode,
  output logic [MODE_COUNT-1:0] mode_onehot,
  output logic                  vm_active,
  output logic                  mgmt_addr_space,
  output logic                  ctx_save_pulse,
  output logic                  ctx_restore_pulse,
  output logic [CTX_W-1:0]      ctx_out,
  output logic [FEAT_W-1:0]     feat_mask,
  output logic                  lin_limit_4g,
  output logic [6:0]            lin_addr_bits,
  output logic                  phys_above_4g,
  output logic [4:0]            gpr_count,
  output logic [4:0]            vec_count,
  output logic [6:0]            gpr_width,
  output logic [3:0]            priv_levels,
  output logic                  hw_task_ok,
  output logic                  task_fault,
  output logic [1:0]            def_op_size,
  output logic [1:0]            def_addr_size,
  output logic [1:0]            eff_op_size,
  output logic [1:0]            eff_addr_size,
  output logic [3:0]            gpr_sel,
  output logic [7:0]            gpr_lane_mask,
  output logic                  reg_fault
);

  // state
  logic [SYNC_STAGES-1:0] sync_reg, sync_next;
  logic                   pin_lvl_reg, pin_lvl_next;
  logic                   pend_reg, pend_next;
  pomc_mode_t             mode_reg, mode_next;
  pomc_mode_t             saved_mode_reg, saved_mode_next;
  logic                   vm_reg, vm_next;
  logic                   saved_vm_reg, saved_vm_next;
  logic [CTX_W-1:0]       saved_ctx_reg, saved_ctx_next;
  logic [CTX_W-1:0]       ctx_out_reg, ctx_out_next;
  logic                   save_reg, save_next;
  logic                   rest_reg, rest_next;
  logic [MODE_COUNT-1:0]  onehot_reg, onehot_next;
  logic [FEAT_W-1:0]      feat_reg, feat_next;
  logic                   lim_reg, lim_next;
  logic [6:0]             lin_reg, lin_next;
  logic                   phys_reg, phys_next;
  logic [4:0]             gcnt_reg, gcnt_next;
  logic [6:0]             gw_reg, gw_next;
  logic [3:0]             priv_reg, priv_next;
  logic                   hwt_reg, hwt_next;
  logic                   tflt_reg, tflt_next;
  logic [1:0]             dop_reg, dad_reg, eop_reg, ead_reg;
  logic [3:0]             gsel_reg;
  logic [7:0]             lane_reg;
  logic                   rflt_reg;
  logic                   pin_assert;
  logic                   take;

  pomc_size_if sz ();

  pomc_size_dec i_pomc_size_dec (
    .sz (sz)
  );

  // pin synchroniser; a level counts once stages two and three agree
  always_comb begin
    sync_next    = {sync_reg[SYNC_STAGES-2:0], mgmt_irq_pin_n};
    pin_lvl_next = pin_lvl_reg;
    if (sync_reg[1] == sync_reg[2]) begin
      pin_lvl_next = sync_reg[2];
    end
    pin_assert = (sync_reg[1] == sync_reg[2]) && !sync_reg[2] && pin_lvl_reg;
  end

  // pending request, set wins over take
  always_comb begin
    take      = pend_reg && (mode_reg != MODE_SMM);
    pend_next = pin_assert || pic_mgmt_msg || (pend_reg && !take);
  end

  // mode state machine with save and restore
  always_comb begin
    mode_next       = mode_reg;
    vm_next         = vm_reg;
    saved_mode_next = saved_mode_reg;
    saved_vm_next   = saved_vm_reg;
    saved_ctx_next  = saved_ctx_reg;
    ctx_out_next    = ctx_out_reg;
    save_next       = 1'b0;
    rest_next       = 1'b0;
    if (take) begin
      mode_next       = MODE_SMM;
      vm_next         = 1'b0;
      saved_mode_next = mode_reg;
      saved_vm_next   = vm_reg;
      saved_ctx_next  = ctx_in;
      save_next       = 1'b1;
    end else begin
      case (mode_reg)
        MODE_REAL: begin
          if (prot_enable_req) begin
            mode_next = MODE_PROT;
          end
        end
        MODE_PROT: begin
          if (prot_disable_req) begin
            mode_next = MODE_REAL;
            vm_next   = 1'b0;
          end else if (cs_load && ext_mode_enable) begin
            mode_next = cs_long ? MODE_LONG64 : MODE_COMPAT;
            vm_next   = 1'b0;
          end else if (task_load) begin
            vm_next = task_vm_attr;
          end
        end
        MODE_SMM: begin
          if (resume_req) begin
            mode_next    = saved_mode_reg;
            vm_next      = saved_vm_reg;
            ctx_out_next = saved_ctx_reg;
            rest_next    = 1'b1;
          end
        end
        MODE_COMPAT, MODE_LONG64: begin
          if (!ext_mode_enable) begin
            mode_next = MODE_PROT;
          end else if (cs_load) begin
            mode_next = cs_long ? MODE_LONG64 : MODE_COMPAT;
          end
        end
        default: begin
          mode_next = MODE_RST;
          vm_next   = 1'b0;
        end
      endcase
    end
  end

  // refuse vm attribute and task switch outside protected, except in management mode
  always_comb begin
    tflt_next = !take && (mode_reg != MODE_SMM) &&
                ((task_switch_req && (mode_reg != MODE_PROT)) ||
                 (task_load && task_vm_attr && (mode_reg != MODE_PROT)));
  end

  // per-mode environment, aligned with the mode being entered
  always_comb begin
    onehot_next = '0;
    onehot_next[mode_next] = 1'b1;
    feat_next = '0;
    lim_next  = 1'b1;
    lin_next  = LIN_W_LEGACY;
    phys_next = 1'b0;
    gcnt_next = GPR_CNT_LEGACY;
    gw_next   = GPR_W_LEGACY;
    priv_next = PRIV_NONE;
    hwt_next  = 1'b0;
    case (mode_next)
      MODE_PROT: begin
        feat_next[FEAT_PROT] = 1'b1;
        feat_next[FEAT_VM]   = 1'b1;
        phys_next = pae_enable;
        priv_next = PRIV_ALL;
        hwt_next  = 1'b1;
      end
      MODE_SMM: begin
        feat_next[FEAT_RESUME] = 1'b1;
      end
      MODE_COMPAT: begin
        feat_next[FEAT_PROT] = 1'b1;
        lim_next  = 1'b1;
        phys_next = pae_enable;
        priv_next = PRIV_ALL;
      end
      MODE_LONG64: begin
        feat_next[FEAT_PROT] = 1'b1;
        feat_next[FEAT_LONG] = 1'b1;
        lim_next  = 1'b0;
        lin_next  = LIN_W_EXT;
        phys_next = 1'b1;
        gcnt_next = GPR_CNT_EXT;
        gw_next   = GPR_W_EXT;
        priv_next = PRIV_ALL;
      end
      default: begin
      end
    endcase
  end

  // extension prefix only decoded in 64-bit
  always_comb begin
    sz.mode     = mode_reg;
    sz.cs_d     = cs_default32;
    sz.rex_w    = rex_present && rex_w && (mode_reg == MODE_LONG64);
    sz.op_ovr   = op_size_prefix;
    sz.ad_ovr   = addr_size_prefix;
    sz.acc_size = reg_acc_size;
    sz.reg_idx  = {rex_present && rex_reg_ext && (mode_reg == MODE_LONG64),
                   reg_idx_in};
  end

  // registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync_reg       <= SYNC_RST;
      pin_lvl_reg    <= 1'b1;
      pend_reg       <= 1'b0;
      mode_reg       <= MODE_RST;
      saved_mode_reg <= MODE_RST;
      vm_reg         <= 1'b0;
      saved_vm_reg   <= 1'b0;
      saved_ctx_reg  <= '0;
      ctx_out_reg    <= '0;
      save_reg       <= 1'b0;
      rest_reg       <= 1'b0;
      onehot_reg     <= '0;
      onehot_reg[MODE_RST] <= 1'b1;
      feat_reg       <= '0;
      lim_reg        <= 1'b1;
      lin_reg        <= LIN_W_LEGACY;
      phys_reg       <= 1'b0;
      gcnt_reg       <= GPR_CNT_LEGACY;
      gw_reg         <= GPR_W_LEGACY;
      priv_reg       <= PRIV_NONE;
      hwt_reg        <= 1'b0;
      tflt_reg       <= 1'b0;
      dop_reg        <= SZ_16;
      dad_reg        <= SZ_16;
      eop_reg        <= SZ_16;
      ead_reg        <= SZ_16;
      gsel_reg       <= '0;
      lane_reg       <= LANES_8;
      rflt_reg       <= 1'b0;
    end else begin
      sync_reg       <= sync_next;
      pin_lvl_reg    <= pin_lvl_next;
      pend_reg       <= pend_next;
      mode_reg       <= mode_next;
      saved_mode_reg <= saved_mode_next;
      vm_reg         <= vm_next;
      saved_vm_reg   <= saved_vm_next;
      saved_ctx_reg  <= saved_ctx_next;
      ctx_out_reg    <= ctx_out_next;
      save_reg       <= save_next;
      rest_reg       <= rest_next;
      onehot_reg     <= onehot_next;
      feat_reg       <= feat_next;
      lim_reg        <= lim_next;
      lin_reg        <= lin_next;
      phys_reg       <= phys_next;
      gcnt_reg       <= gcnt_next;
      gw_reg         <= gw_next;
      priv_reg       <= priv_next;
      hwt_reg        <= hwt_next;
      tflt_reg       <= tflt_next;
      dop_reg        <= sz.def_op;
      dad_reg        <= sz.def_ad;
      eop_reg        <= sz.eff_op;
      ead_reg        <= sz.eff_ad;
      gsel_reg       <= sz.reg_idx;
      lane_reg       <= sz.lane_mask;
      rflt_reg       <= sz.reg_fault;
    end
  end

  // outputs straight from flip-flops
  assign cur_mode          = mode_reg;
  assign mode_onehot       = onehot_reg;
  assign vm_active         = vm_reg;
  assign mgmt_addr_space   = onehot_reg[MODE_SMM] ? ASPACE_MGMT
                                                  : ASPACE_NORMAL;
  assign ctx_save_pulse    = save_reg;
  assign ctx_restore_pulse = rest_reg;
  assign ctx_out           = ctx_out_reg;
  assign feat_mask         = feat_reg;
  assign lin_limit_4g      = lim_reg;
  assign lin_addr_bits     = lin_reg;
  assign phys_above_4g     = phys_reg;
  assign gpr_count         = gcnt_reg;
  assign vec_count         = gcnt_reg;
  assign gpr_width         = gw_reg;
  assign priv_levels       = priv_reg;
  assign hw_task_ok        = hwt_reg;
  assign task_fault        = tflt_reg;
  assign def_op_size       = dop_reg;
  assign def_addr_size     = dad_reg;
  assign eff_op_size       = eop_reg;
  assign eff_addr_size     = ead_reg;
  assign gpr_sel           = gsel_reg;
  assign gpr_lane_mask     = lane_reg;
  assign reg_fault         = rflt_reg;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_reset_real;
    $fell(rst) |-> (mode_reg == MODE_REAL) && onehot_reg[MODE_REAL];
  endproperty
  a_reset_real: assert property (p_reset_real)
    else $error("mode not real after reset");

  property p_onehot;
    $onehot(onehot_reg) && onehot_reg[mode_reg];
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("mode view not one-hot or out of step");

  property p_pin_entry;
    pin_assert && (mode_reg != MODE_SMM) |=> ##1 (mode_reg == MODE_SMM);
  endproperty
  a_pin_entry: assert property (p_pin_entry)
    else $error("pin request did not enter management mode");

  property p_save;
    take |=> save_reg && (saved_mode_reg == $past(mode_reg)) &&
             (saved_ctx_reg == $past(ctx_in)) && mgmt_addr_space;
  endproperty
  a_save: assert property (p_save)
    else $error("context not saved on entry");

  property p_restore;
    (mode_reg == MODE_SMM) && resume_req && !take |=>
      rest_reg && (mode_reg == $past(saved_mode_reg)) &&
      (vm_reg == $past(saved_vm_reg)) && (ctx_out == $past(saved_ctx_reg));
  endproperty
  a_restore: assert property (p_restore)
    else $error("state not restored on return");

  property p_no_vm_outside_prot;
    (mode_reg != MODE_PROT) |-> !vm_reg;
  endproperty
  a_no_vm_outside_prot: assert property (p_no_vm_outside_prot)
    else $error("virtual attribute set outside protected mode");

  property p_compat_env;
    (mode_reg == MODE_COMPAT) |-> lim_reg && !hwt_reg ##1
      (eop_reg != SZ_64) && (dad_reg != SZ_64) && (ead_reg != SZ_64);
  endproperty
  a_compat_env: assert property (p_compat_env)
    else $error("compat mode used 64-bit size or wide space");

  property p_long_env;
    (mode_reg == MODE_LONG64) |-> (gcnt_reg == GPR_CNT_EXT) &&
      (gw_reg == GPR_W_EXT) && !lim_reg ##1
      (dad_reg == SZ_64) && (dop_reg == SZ_32);
  endproperty
  a_long_env: assert property (p_long_env)
    else $error("64-bit environment or default sizes wrong");

  property p_rex_outside;
    rex_present && rex_reg_ext && (mode_reg != MODE_LONG64) |=> !gsel_reg[3];
  endproperty
  a_rex_outside: assert property (p_rex_outside)
    else $error("extension prefix decoded outside 64-bit mode");

  c_smm_entry: cover property (take ##1 save_reg);
  c_smm_resume: cover property (save_reg ##[1:20] rest_reg);
  c_long64: cover property ((mode_reg == MODE_PROT) ##1
                            (mode_reg == MODE_LONG64));
  c_compat: cover property ((mode_reg == MODE_LONG64) ##1
                            (mode_reg == MODE_COMPAT));

endmodule

// File: bench/pomc_mgmt_src.sv
// platform-side source of management interrupts for the mode block
// assumes the bench raises pin_req and msg_req off the rising edge
`timescale 1ns/1ps
module pomc_mgmt_src (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic pin_req,
  input  wire logic msg_req,
  output logic      mgmt_irq_pin_n,
  output logic      pic_mgmt_msg
);
  logic pin_n_next;
  logic msg_next;

  always_comb begin
    pin_n_next = ~pin_req;
    msg_next   = msg_req;
  end

  // pin idles high, message is a one-cycle pulse per request cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mgmt_irq_pin_n <= 1'b1;
      pic_mgmt_msg   <= 1'b0;
    end else begin
      mgmt_irq_pin_n <= pin_n_next;
      pic_mgmt_msg   <= msg_next;
    end
  end
endmodule

// File: bench/pomc_mode_ctrl_tb.sv
// self-checking bench for the operating-mode control block
// assumes pomc_pkg, the design and the management source are compiled
`timescale 1ns/1ps
module pomc_mode_ctrl_tb
  import pomc_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        pin_req, msg_req, resume_req, prot_enable_req;
  logic        prot_disable_req, ext_mode_enable, cs_load, cs_long;
  logic        cs_default32, task_load, task_vm_attr, task_switch_req;
  logic        pae_enable, rex_present, rex_w, rex_reg_ext;
  logic        op_size_prefix, addr_size_prefix;
  logic [31:0] ctx_in, ctx_out;
  logic [2:0]  reg_idx_in;
  logic [1:0]  reg_acc_size, def_op_size, def_addr_size;
  logic [1:0]  eff_op_size, eff_addr_size;
  logic        mgmt_irq_pin_n, pic_mgmt_msg, vm_active, mgmt_addr_space;
  logic        ctx_save_pulse, ctx_restore_pulse, lin_limit_4g;
  logic        phys_above_4g, hw_task_ok, task_fault, reg_fault;
  pomc_mode_t  cur_mode;
  logic [4:0]  mode_onehot, gpr_count, vec_count;
  logic [3:0]  feat_mask, priv_levels, gpr_sel;
  logic [6:0]  lin_addr_bits, gpr_width;
  logic [7:0]  gpr_lane_mask;
  int          err_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  pomc_mgmt_src i_pomc_mgmt_src (.clk_sys, .rst, .pin_req, .msg_req,
    .mgmt_irq_pin_n, .pic_mgmt_msg);

  pomc_mode_ctrl i_pomc_mode_ctrl (.clk_sys, .rst, .mgmt_irq_pin_n,
    .pic_mgmt_msg, .resume_req, .prot_enable_req, .prot_disable_req,
    .ext_mode_enable, .cs_load, .cs_long, .cs_default32, .task_load,
    .task_vm_attr, .task_switch_req, .pae_enable, .ctx_in, .rex_present,
    .rex_w, .rex_reg_ext, .op_size_prefix, .addr_size_prefix, .reg_idx_in,
    .reg_acc_size, .cur_mode, .mode_onehot, .vm_active, .mgmt_addr_space,
    .ctx_save_pulse, .ctx_restore_pulse, .ctx_out, .feat_mask,
    .lin_limit_4g, .lin_addr_bits, .phys_above_4g, .gpr_count, .vec_count,
    .gpr_width, .priv_levels, .hw_task_ok, .task_fault, .def_op_size,
    .def_addr_size, .eff_op_size, .eff_addr_size, .gpr_sel, .gpr_lane_mask,
    .reg_fault);

  // 200 MHz core clock
  always #2.5 clk_sys = ~clk_sys;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle strobe; returns once the taking edge has landed
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // hang guard
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 1000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic t_prot();
    chk(cur_mode, MODE_REAL);
    chk(mode_onehot, 5'h01);
    chk(def_op_size, SZ_16);
    pulse(prot_enable_req);
    chk(cur_mode, MODE_PROT);
    chk(mode_onehot, 5'h02);
    chk(hw_task_ok, 1'b1);
    task_vm_attr = 1'b1;
    pulse(task_load);
    task_vm_attr = 1'b0;
    chk(vm_active, 1'b1);
    $display("test protected done");
  endtask

  task automatic t_msg();
    ctx_in = 32'h5a5a0f0f;
    pulse(msg_req);
    // source flop, pending flag, then entry: save pulse stands one cycle
    repeat (2) @(negedge clk_sys);
    chk(cur_mode, MODE_SMM);
    chk(ctx_save_pulse, 1'b1);
    chk(mgmt_addr_space, ASPACE_MGMT);
    chk(vm_active, 1'b0);
    chk(feat_mask, 4'h4);
    ctx_in = 32'h0;
    @(negedge clk_sys);
    chk(ctx_save_pulse, 1'b0);
    pulse(resume_req);
    chk(cur_mode, MODE_PROT);
    chk(vm_active, 1'b1);
    chk(ctx_out, 32'h5a5a0f0f);
    chk(ctx_restore_pulse, 1'b1);
    $display("test message entry done");
  endtask

  task automatic t_compat();
    ext_mode_enable = 1'b1;
    pae_enable = 1'b1;
    cs_default32 = 1'b1;
    pulse(cs_load);
    chk(cur_mode, MODE_COMPAT);
    chk(lin_limit_4g, 1'b1);
    chk(lin_addr_bits, LIN_W_LEGACY);
    chk(phys_above_4g, 1'b1);
    chk(priv_levels, PRIV_ALL);
    chk(hw_task_ok, 1'b0);
    chk(vm_active, 1'b0);
    // fault pulse stands in the cycle after the request edge
    pulse(task_switch_req);
    chk(task_fault, 1'b1);
    {rex_present, rex_w} = 2'h3;
    reg_acc_size = SZ_64;
    @(negedge clk_sys);
    chk(eff_op_size, SZ_32);
    chk(reg_fault, 1'b1);
    $display("test compatibility done");
  endtask

  task automatic t_long();
    logic [1:0] op_exp[4];
    logic [7:0] lane_exp[4];
    op_exp = '{SZ_32, SZ_16, SZ_64, SZ_64};
    lane_exp = '{LANES_8, LANES_16, LANES_32, LANES_64};
    cs_long = 1'b1;
    pulse(cs_load);
    chk(cur_mode, MODE_LONG64);
    chk(gpr_count, GPR_CNT_EXT);
    chk(vec_count, GPR_CNT_EXT);
    chk(gpr_width, GPR_W_EXT);
    chk(lin_addr_bits, LIN_W_EXT);
    @(negedge clk_sys);
    chk(def_addr_size, SZ_64);
    chk(def_op_size, SZ_32);
    rex_reg_ext = 1'b1;
    reg_idx_in = 3'h5;
    for (int i = 0; i < 4; i++) begin
      {rex_w, op_size_prefix} = i[1:0];
      reg_acc_size = i[1:0];
      @(negedge clk_sys);
      chk(eff_op_size, op_exp[i]);
      chk(gpr_lane_mask, lane_exp[i]);
      chk(reg_fault, 1'b0);
    end
    chk(gpr_sel, 4'hd);
    addr_size_prefix = 1'b1;
    @(negedge clk_sys);
    chk(eff_addr_size, SZ_32);
    $display("test 64-bit done");
  endtask

  task automatic t_pin();
    pin_req = 1'b1;
    for (int n = 0; n < 12 && cur_mode !== MODE_SMM; n++)
      @(negedge clk_sys);
    pin_req = 1'b0;
    chk(cur_mode, MODE_SMM);
    chk(mode_onehot, 5'h04);
    repeat (6) @(negedge clk_sys);
    pulse(resume_req);
    chk(cur_mode, MODE_LONG64);
    ext_mode_enable = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(cur_mode, MODE_PROT);
    pulse(prot_disable_req);
    chk(cur_mode, MODE_REAL);
    $display("test pin entry done");
  endtask

  // reset, then the scenarios in mode order
  initial begin
    {pin_req, msg_req, resume_req, prot_enable_req, prot_disable_req,
     ext_mode_enable, cs_load, cs_long, cs_default32, task_load,
     task_vm_attr, task_switch_req, pae_enable, rex_present, rex_w,
     rex_reg_ext, op_size_prefix, addr_size_prefix} = '0;
    ctx_in = 32'h0;
    reg_idx_in = 3'h0;
    reg_acc_size = 2'h0;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    t_prot();
    t_msg();
    t_compat();
    t_long();
    t_pin();
    print_verdict();
  end
endmodule
